/* File: logic/spms_port.sv */
// serial peripheral port: byte fifo and master/slave engine with its register file
`default_nettype none
`include "spms_consts.svh"
// Contract
// - full duplex, one byte out and one byte in together, eight bits each
// - double buffered so software reads and loads while a byte shifts
// - works as master making the clock or slave taking an external clock
// - pins shared with two-wire unit; owner select picks the active one
// - writing transmit buffer pushes the byte into the transmit fifo
// - reading receive buffer pops one byte from the receive fifo
// - cause select 0 raises interrupt on each byte taken into the receive fifo, 1 on transmit empty
// - master with automatic select cleared holds slave select low
// - master with automatic select set drives select low per byte or burst
// - slave with select input enabled uses the select pin as select
// - overwrite off and receive buffer unread: new byte is discarded
// - overwrite on and receive buffer unread: new byte replaces old one
// - master clock is core clock divided by 8, 16, 32 or 64
// - continuous off stops after each byte; on keeps going while data remains
// - port enable 0 disables the port, 1 enables it
// - master select 0 makes a slave, 1 makes a master
// - clock polarity sets the idle level and first edge direction

// ****************************************
// byte fifo
// ****************************************
module spms_fifo #(
  parameter int W = 8,
  parameter int D = `SPMS_FIFO_DEPTH
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // pointers and count; a full fifo still takes a byte when one leaves
  always_comb begin
    out_valid_o = (cnt_q != '0);
    in_ready_o  = (cnt_q != (AW+1)'(D)) || out_ready_i;
    out_data_o  = mem_q[rp_q];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    mem_d       = mem_q;
    wp_d        = wp_q;
    rp_d        = rp_q;
    cnt_d       = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data_i;
      wp_d        = (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule

// ****************************************
// port top
// ****************************************
module spms_port (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire spms_pkg::spms_sfr_s sfr_i,
  output logic [7:0]              sfr_rdata_o,
  input  wire logic               pin_owner_select_i,
  input  wire spms_pkg::spms_pin_s pin_i,
  output spms_pkg::spms_pin_s     pin_o,
  output spms_pkg::spms_pin_s     pin_oe_o,
  output logic                    irq_o
);
  import spms_pkg::*;

  logic [7:0]  cfg1_q, cfg1_d, cfg2_q, cfg2_d, rxbuf_q, rxbuf_d, rdata_q, rdata_d;
  logic        irq_q, irq_d, ovf_q, ovf_d, txv_prev_q;
  spms_state_e st_q, st_d;
  logic [4:0]  div_q, div_d, half;
  logic [3:0]  edge_q, edge_d;
  logic        sclk_q, sclk_d, ss_q, ss_d, loaded_q, loaded_d, sclk_prev_q;
  logic [7:0]  txsh_q, txsh_d, rxsh_q, rxsh_d;
  logic        active, master, slave, selected, cpol, cpha, din, samp, chg, step;
  logic        tx_wr, tx_in_ready, tx_valid, tx_pop;
  logic [7:0]  tx_data, rx_data;
  logic        rx_rd, rx_push, rx_in_ready, rx_valid, rx_pop, rx_full, rx_acc, tx_empty_evt;
  logic [4:0]  rxn_q, rxn_d;

  // ****************************************
  // mode decode
  // ****************************************
  assign active   = cfg2_q[`SPMS_C2_EN] && !pin_owner_select_i;
  assign master   = active && cfg2_q[`SPMS_C2_MS];
  assign slave    = active && !cfg2_q[`SPMS_C2_MS];
  assign selected = !cfg1_q[`SPMS_C1_SSEN] || !pin_i.ss_n;
  assign cpol     = cfg2_q[`SPMS_C2_CPOL];
  assign cpha     = cfg2_q[`SPMS_C2_CPHA];
  assign half     = 5'((`SPMS_HALF_BASE << cfg1_q[1:0]) - 6'd1);
  assign din      = master ? pin_i.miso : pin_i.mosi;
  assign samp     = (edge_q[0] == cpha);
  assign chg      = !samp && !(cpha ? (edge_q == 4'd0) : (edge_q == `SPMS_LAST_EDGE));

  // ****************************************
  // fifos
  // ****************************************
  assign tx_wr = sfr_i.wr && (sfr_i.addr == `SPMS_ADDR_TX);
  assign rx_rd = sfr_i.rd && (sfr_i.addr == `SPMS_ADDR_RX);
  // overwrite drops the oldest byte only when the receive fifo is full
  assign rx_full = (rxn_q == 5'(`SPMS_FIFO_DEPTH));
  assign rx_pop  = rx_rd || (rx_push && cfg1_q[`SPMS_C1_OFW] && rx_full);
  assign rx_acc  = rx_push && rx_in_ready;

  spms_fifo #(.W(8), .D(`SPMS_FIFO_DEPTH)) u_txf (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (tx_wr),
    .in_ready_o (tx_in_ready),
    .in_data_i  (sfr_i.wdata),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_pop),
    .out_data_o (tx_data)
  );

  spms_fifo #(.W(8), .D(`SPMS_FIFO_DEPTH)) u_rxf (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (rx_push),
    .in_ready_o (rx_in_ready),
    .in_data_i  (rxsh_d),
    .out_valid_o(rx_valid),
    .out_ready_i(rx_pop),
    .out_data_o (rx_data)
  );

  // ****************************************
  // shift engine
  // ****************************************
  // one bit step per clock edge: sample or change per phase, byte ends at edge 15
  always_comb begin
    st_d = st_q; div_d = div_q; edge_d = edge_q; sclk_d = sclk_q;
    txsh_d = txsh_q; rxsh_d = rxsh_q; loaded_d = loaded_q;
    tx_pop = 1'b0; rx_push = 1'b0; step = 1'b0;
    if (!active) begin
      st_d = SPMS_IDLE; sclk_d = cpol; edge_d = 4'd0; loaded_d = 1'b0;
    end else if (master) begin
      unique case (st_q)
        SPMS_IDLE: begin
          sclk_d = cpol;
          if (tx_valid) begin
            tx_pop = 1'b1; txsh_d = tx_data; st_d = SPMS_RUN; edge_d = 4'd0; div_d = half;
          end
        end
        SPMS_RUN: begin
          if (div_q == 5'd0) begin
            div_d = half; sclk_d = !sclk_q; step = 1'b1;
          end else begin
            div_d = div_q - 5'd1;
          end
        end
        SPMS_GAP: begin
          sclk_d = cpol;
          if (div_q == 5'd0) st_d = SPMS_IDLE;
          else div_d = div_q - 5'd1;
        end
        default: st_d = SPMS_IDLE;
      endcase
    end else if (!selected) begin
      edge_d = 4'd0; loaded_d = 1'b0;
    end else begin
      if (!loaded_q) begin
        tx_pop = tx_valid; txsh_d = tx_valid ? tx_data : `SPMS_RST_BUF; loaded_d = 1'b1;
      end
      step = loaded_q && (pin_i.sclk != sclk_prev_q);
    end
    // shared bit step for both roles, full duplex
    if (step) begin
      edge_d = edge_q + 4'd1;
      if (samp) rxsh_d = {rxsh_q[6:0], din};
      if (chg) txsh_d = {txsh_q[6:0], 1'b0};
      if (edge_q == `SPMS_LAST_EDGE) begin
        rx_push = 1'b1; loaded_d = 1'b0;
        if (master) begin
          if (cfg2_q[`SPMS_C2_CONT] && tx_valid) begin
            tx_pop = 1'b1; txsh_d = tx_data; edge_d = 4'd0;
          end else begin
            st_d = SPMS_GAP;
          end
        end
      end
    end
    // select output: manual low or low across the byte or burst
    if (!cfg1_q[`SPMS_C1_AUTOSS]) ss_d = 1'b0;
    else ss_d = !(master && st_d == SPMS_RUN);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q <= SPMS_IDLE; div_q <= '0; edge_q <= '0; sclk_q <= 1'b0; ss_q <= 1'b1;
      txsh_q <= '0; rxsh_q <= '0; loaded_q <= 1'b0; sclk_prev_q <= 1'b0;
    end else begin
      st_q <= st_d; div_q <= div_d; edge_q <= edge_d; sclk_q <= sclk_d; ss_q <= ss_d;
      txsh_q <= txsh_d; rxsh_q <= rxsh_d; loaded_q <= loaded_d; sclk_prev_q <= pin_i.sclk;
    end
  end

  // pin drive: master owns clock, data out and select; slave owns miso when chosen
  always_comb begin
    pin_o        = '0;
    pin_oe_o     = '0;
    pin_o.sclk   = sclk_q;
    pin_o.mosi   = txsh_q[7];
    pin_o.miso   = txsh_q[7];
    pin_o.ss_n   = ss_q;
    pin_oe_o.sclk = master;
    pin_oe_o.mosi = master;
    pin_oe_o.ss_n = master;
    pin_oe_o.miso = slave && selected;
  end

  // ****************************************
  // register file
  // ****************************************
  // register writes, reads and sticky flags; a set beats a clear
  assign tx_empty_evt = txv_prev_q && !tx_valid;
  always_comb begin
    cfg1_d = cfg1_q; cfg2_d = cfg2_q; irq_d = irq_q; ovf_d = ovf_q;
    rxbuf_d = rxbuf_q; rdata_d = rdata_q;
    rxn_d = rxn_q;
    if (sfr_i.wr) begin
      unique case (sfr_i.addr)
        `SPMS_ADDR_CFG1: cfg1_d = sfr_i.wdata & `SPMS_CFG1_WMASK;
        `SPMS_ADDR_CFG2: cfg2_d = sfr_i.wdata;
        `SPMS_ADDR_STAT: begin
          if (sfr_i.wdata[`SPMS_ST_IRQ]) irq_d = 1'b0;
          if (sfr_i.wdata[`SPMS_ST_OVF]) ovf_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (rx_push && !rx_in_ready) ovf_d = 1'b1;
    if (cfg1_q[`SPMS_C1_CAUSE] ? tx_empty_evt : rx_acc) irq_d = 1'b1;
    if (rx_rd && rx_valid) rxbuf_d = rx_data;
    // receive fill count follows the fifo's own push and pop
    if (rx_acc && !(rx_pop && rx_valid)) rxn_d = rxn_q + 5'd1;
    else if (!rx_acc && rx_pop && rx_valid) rxn_d = rxn_q - 5'd1;
    if (sfr_i.rd) begin
      unique case (sfr_i.addr)
        `SPMS_ADDR_RX:   rdata_d = (rx_valid) ? rx_data : rxbuf_q;
        `SPMS_ADDR_CFG1: rdata_d = cfg1_q;
        `SPMS_ADDR_CFG2: rdata_d = cfg2_q;
        `SPMS_ADDR_STAT: rdata_d = {2'b00, !tx_in_ready, st_q != SPMS_IDLE,
                                    rx_valid, !tx_valid, ovf_q, irq_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg1_q <= `SPMS_RST_CFG1; cfg2_q <= `SPMS_RST_CFG2; irq_q <= 1'b0; ovf_q <= 1'b0;
      rxbuf_q <= `SPMS_RST_BUF; rdata_q <= 8'h00; txv_prev_q <= 1'b0;
      rxn_q <= '0;
    end else begin
      cfg1_q <= cfg1_d; cfg2_q <= cfg2_d; irq_q <= irq_d; ovf_q <= ovf_d;
      rxbuf_q <= rxbuf_d; rdata_q <= rdata_d; txv_prev_q <= tx_valid;
      rxn_q <= rxn_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign irq_o       = irq_q;

  // ****************************************
  // checks
  // ****************************************
  chk_rate_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (master && st_q == SPMS_RUN && div_q == 5'd0 && $stable(cfg1_q)) |=> (div_q == $past(half)))
    else $error("divider reload differs from rate field");
  chk_manual_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (master && !cfg1_q[`SPMS_C1_AUTOSS]) |=> !pin_o.ss_n)
    else $error("select not held low in manual mode");
  chk_auto_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (master && cfg1_q[`SPMS_C1_AUTOSS] && st_q == SPMS_GAP) |=> pin_o.ss_n)
    else $error("select not released after transfer");
  chk_idle_clock: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (master && st_q == SPMS_IDLE && $stable(cfg2_q)) |=> (pin_o.sclk == $past(cpol)))
    else $error("clock idle level wrong");
  chk_rx_discard: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rx_push && !rx_rd && !cfg1_q[`SPMS_C1_OFW] && !rx_in_ready) |=> ovf_q)
    else $error("discarded byte not flagged");
  chk_rx_replace: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rx_push && cfg1_q[`SPMS_C1_OFW] && rx_full) |-> (rx_acc && rx_pop) ##1 (rx_full && rx_valid))
    else $error("overwrite did not replace");
  chk_tx_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (tx_wr && tx_in_ready) |=> tx_valid)
    else $error("written byte missing from fifo");
  chk_irq_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!cfg1_q[`SPMS_C1_CAUSE] && rx_acc) |=> irq_o)
    else $error("receive interrupt not raised");
  chk_disabled_pins: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!active) |-> (pin_oe_o == '0) ##1 (st_q == SPMS_IDLE))
    else $error("disabled port still active");
  chk_byte_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (master && step && edge_q == `SPMS_LAST_EDGE && !cfg2_q[`SPMS_C2_CONT]) |=> (st_q == SPMS_GAP))
    else $error("single byte transfer did not stop");
endmodule
`default_nettype wire

/* File: logic/spms_consts.svh */
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPMS_CONSTS_SVH
`define SPMS_CONSTS_SVH
`define SPMS_ADDR_TX    8'h9a
`define SPMS_ADDR_RX    8'h9b
`define SPMS_ADDR_CFG1  8'he8
`define SPMS_ADDR_CFG2  8'he9
`define SPMS_ADDR_STAT  8'hea
`define SPMS_RST_CFG1   8'h10
`define SPMS_RST_CFG2   8'h00
`define SPMS_RST_BUF    8'h00
`define SPMS_CFG1_WMASK 8'h3f
`define SPMS_C1_CAUSE   5
`define SPMS_C1_AUTOSS  4
`define SPMS_C1_SSEN    3
`define SPMS_C1_OFW     2
`define SPMS_C2_CONT    7
`define SPMS_C2_EN      6
`define SPMS_C2_MS      4
`define SPMS_C2_CPOL    3
`define SPMS_C2_CPHA    2
`define SPMS_ST_IRQ     0
`define SPMS_ST_OVF     1
`define SPMS_ST_TXEMPTY 2
`define SPMS_ST_RXAVAIL 3
`define SPMS_ST_BUSY    4
`define SPMS_ST_TXFULL  5
`define SPMS_HALF_BASE  6'd4
`define SPMS_LAST_EDGE  4'd15
`define SPMS_FIFO_DEPTH 16
`endif

/* File: logic/spms_pkg.sv */
// types shared by the serial port design
`default_nettype none
package spms_pkg;
  typedef enum logic [1:0] {SPMS_IDLE, SPMS_RUN, SPMS_GAP} spms_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } spms_sfr_s;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } spms_pin_s;
endpackage
`default_nettype wire

/* File: bench/spms_slave_model.sv */
// behavioural serial slave that answers the port in master mode
`default_nettype none
module spms_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  input  wire logic       cpol_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o,
  output int              cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] rx;
  int         bits;
  wire logic  lead = sclk_i ^ cpol_i;
  // start quiet
  initial begin
    miso_o = 1'b0;
    got_o = 8'h00;
    cnt_o = 0;
    bits = 0;
    sh = 8'h00;
    rx = 8'h00;
  end
  // reply byte loads as select falls, msb out at once
  always @(negedge ss_n_i) begin
    sh = reply_i + cnt_o[7:0];
    bits = 0;
    miso_o = sh[7];
  end
  // released line shows the inverse of its last value
  always @(posedge ss_n_i) miso_o = ~miso_o;
  // leading edge samples; eight bits make a byte
  always @(posedge lead) if (!ss_n_i) begin
    rx = {rx[6:0], mosi_i};
    bits++;
    if (bits == 8) begin
      got_o = rx;
      cnt_o++;
      bits = 0;
      sh = reply_i + cnt_o[7:0];
    end
  end
  // trailing edge moves to the next bit
  always @(negedge lead) if (!ss_n_i) begin
    if (bits != 0) sh = sh << 1;
    miso_o = sh[7];
  end
endmodule
`default_nettype wire

/* File: bench/spms_port_tb.sv */
// self-checking bench for the serial port in master and slave mode
`default_nettype none
`include "spms_consts.svh"
module spms_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spms_pkg::*;
  logic       core_clk_i;
  logic       rst_i;
  logic       own;
  logic       cpol;
  logic       m_miso;
  logic       irq;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [7:0] reply;
  logic [7:0] v;
  logic       x_sclk;
  logic       x_mosi;
  logic       x_ss_n;
  spms_sfr_s  sfr;
  spms_pin_s  pin_o;
  spms_pin_s  pin_oe;
  spms_pin_s  pin_w;
  int         cnt;
  int         c0;
  int         miscompares;
  int         n_tests;
  // wire levels: port's driven value, else the external master's or model's level
  assign pin_w = {pin_oe.sclk ? pin_o.sclk : x_sclk, pin_oe.mosi ? pin_o.mosi : x_mosi,
                  pin_oe.miso ? pin_o.miso : m_miso, pin_oe.ss_n ? pin_o.ss_n : x_ss_n};
  spms_port i_spms_port (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .pin_owner_select_i(own), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe), .irq_o(irq));
  spms_slave_model i_spms_slave_model (.sclk_i(pin_w.sclk), .mosi_i(pin_w.mosi), .ss_n_i(pin_w.ss_n),
    .cpol_i(cpol), .reply_i(reply), .miso_o(m_miso), .got_o(got), .cnt_o(cnt));
  // core clock, 10 ns
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    step(1);
    sfr.wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    step(1);
    sfr.rd = 1'b0;
    step(1);
    v = rdata;
  endtask
  // wait for the model to count n bytes, then let the tail land
  task automatic wait_cnt(input int n);
    for (int i = 0; i < 20000 && cnt < n; i++) step(1);
    if (cnt < n) begin
      miscompares++;
      $display("[ERR] %0t model byte count stalled", $time);
    end
    step(100);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    chk(pin_oe, 4'h0);
    rd(`SPMS_ADDR_CFG1);
    chk(v, 8'h10);
    rd(`SPMS_ADDR_CFG2);
    chk(v, 8'h00);
    rd(`SPMS_ADDR_RX);
    chk(v, 8'h00);
    wr(`SPMS_ADDR_CFG1, 8'hff);
    rd(`SPMS_ADDR_CFG1);
    chk(v, 8'h3f);
    rd(8'h55);
    chk(v, 8'h00);
    wr(`SPMS_ADDR_CFG1, 8'h10);
    $display("reset test done");
  endtask
  task automatic t_master();
    c0 = cnt;
    wr(`SPMS_ADDR_CFG2, 8'h50);
    wr(`SPMS_ADDR_TX, 8'ha5);
    wait_cnt(c0 + 1);
    chk(got, 8'ha5);
    chk(irq, 1'b1);
    chk(pin_o.ss_n, 1'b1);
    rd(`SPMS_ADDR_RX);
    chk(v, reply + c0[7:0]);
    wr(`SPMS_ADDR_STAT, 8'h01);
    chk(irq, 1'b0);
    $display("master test done");
  endtask
  task automatic t_rate();
    time t0;
    for (int r = 0; r < 4; r++) begin
      wr(`SPMS_ADDR_CFG1, 8'h10 | r[7:0]);
      c0 = cnt;
      wr(`SPMS_ADDR_TX, r[7:0]);
      @(posedge pin_o.sclk);
      t0 = $time;
      @(posedge pin_o.sclk);
      chk(($time - t0) / 10, 8 << r);
      wait_cnt(c0 + 1);
      rd(`SPMS_ADDR_RX);
    end
    wr(`SPMS_ADDR_CFG1, 8'h10);
    $display("rate test done");
  endtask
  task automatic t_cont();
    logic bad;
    bad = 1'b0;
    c0 = cnt;
    wr(`SPMS_ADDR_CFG2, 8'hd0);
    wr(`SPMS_ADDR_TX, 8'h11);
    wr(`SPMS_ADDR_TX, 8'h22);
    for (int i = 0; i < 3000 && cnt < c0 + 2; i++) begin
      step(1);
      if (cnt == c0 + 1 && pin_o.ss_n !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0);
    chk(got, 8'h22);
    step(100);
    chk(pin_o.ss_n, 1'b1);
    rd(`SPMS_ADDR_RX);
    rd(`SPMS_ADDR_RX);
    wr(`SPMS_ADDR_CFG2, 8'h50);
    $display("continuous test done");
  endtask
  // seventeen bytes into a sixteen deep receive fifo
  task automatic t_ofw(input logic ofw);
    wr(`SPMS_ADDR_CFG1, {5'h04, ofw, 2'h0});
    c0 = cnt;
    for (int i = 1; i <= 17; i++) begin
      wr(`SPMS_ADDR_TX, i[7:0]);
      wait_cnt(c0 + i);
    end
    rd(`SPMS_ADDR_STAT);
    chk(v[3:1], {2'b11, ~ofw});
    wr(`SPMS_ADDR_STAT, 8'h02);
    rd(`SPMS_ADDR_RX);
    chk(v, reply + c0[7:0] + ofw);
    repeat (15) rd(`SPMS_ADDR_RX);
    $display("overwrite test done");
  endtask
  task automatic t_cause();
    wr(`SPMS_ADDR_CFG1, 8'h30);
    wr(`SPMS_ADDR_STAT, 8'h01);
    chk(irq, 1'b0);
    c0 = cnt;
    wr(`SPMS_ADDR_TX, 8'h5a);
    step(4);
    chk(irq, 1'b1);
    wait_cnt(c0 + 1);
    rd(`SPMS_ADDR_RX);
    wr(`SPMS_ADDR_CFG1, 8'h10);
    $display("cause test done");
  endtask
  task automatic t_pins();
    wr(`SPMS_ADDR_CFG1, 8'h00);
    step(3);
    chk(pin_o.ss_n, 1'b0);
    wr(`SPMS_ADDR_CFG1, 8'h10);
    step(3);
    chk(pin_o.ss_n, 1'b1);
    cpol = 1'b1;
    wr(`SPMS_ADDR_CFG2, 8'h58);
    step(3);
    chk(pin_w.sclk, 1'b1);
    c0 = cnt;
    wr(`SPMS_ADDR_TX, 8'h96);
    wait_cnt(c0 + 1);
    chk(got, 8'h96);
    rd(`SPMS_ADDR_RX);
    own = 1'b1;
    step(3);
    chk(pin_oe, 4'h0);
    own = 1'b0;
    wr(`SPMS_ADDR_CFG2, 8'h40);
    wr(`SPMS_ADDR_CFG1, 8'h18);
    step(3);
    chk({pin_oe.sclk, pin_oe.miso}, 2'b00);
    wr(`SPMS_ADDR_CFG2, 8'h00);
    chk(pin_oe, 4'h0);
    $display("pin test done");
  endtask
  // bench plays the external master: select low, eight clock pulses, msb first
  task automatic t_slave();
    logic [7:0] r;
    logic [7:0] s;
    r = 8'h00;
    s = 8'h5e;
    wr(`SPMS_ADDR_CFG1, 8'h18);
    wr(`SPMS_ADDR_CFG2, 8'h40);
    wr(`SPMS_ADDR_TX, 8'hc3);
    x_ss_n = 1'b0;
    step(2);
    chk(pin_oe, 4'h2);
    for (int i = 7; i >= 0; i--) begin
      x_mosi = s[i];
      step(4);
      r = {r[6:0], pin_w.miso};
      x_sclk = 1'b1;
      step(4);
      x_sclk = 1'b0;
      step(4);
    end
    x_ss_n = 1'b1;
    step(2);
    chk(r, 8'hc3);
    rd(`SPMS_ADDR_RX);
    chk(v, 8'h5e);
    wr(`SPMS_ADDR_CFG2, 8'h00);
    $display("slave test done");
  endtask
  // watchdog
  initial begin
    #500000;
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    own = 1'b0;
    cpol = 1'b0;
    x_sclk = 1'b0;
    x_mosi = 1'b1;
    x_ss_n = 1'b1;
    reply = 8'h3c;
    sfr = '0;
    rst_i = 1'b1;
    step(4);
    rst_i = 1'b0;
    t_reset();
    t_master();
    t_rate();
    t_cont();
    t_ofw(1'b0);
    t_ofw(1'b1);
    t_cause();
    t_pins();
    t_slave();
    results();
  end
endmodule
`default_nettype wire
